// ### core/pic_unit.sv
/*
 * peripheral and pin interrupt unit: detects peripheral and pin
 * requests, merges groups, maps vector slots, presents one vector.
 * assumes peripheral sources come from logic on aclk and pins are
 * asynchronous; the core pulses core_ack when it takes a vector.
 */
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - each peripheral source is edge or level detected, fixed in hardware.
// - several peripheral sources can merge into one group request.
// - one edge group collects slow peripheral clock sources.
// - three level groups collect slow peripheral clock sources.
// - two level groups collect fast peripheral clock sources.
// - slow sources map by software to vectors 128 through 207.
// - fast sources map by software to vectors 208 through 255.
// - sixteen external pins, 0 to 15, are each a source.
// - pins detect low level, falling, rising or both edges.
// - every pin has its own detection mode setting.
// - optional digital noise filter on each pin input.
module pic_unit
    import pic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [SLOW_N-1:0] slow_src,
    input wire logic [FAST_N-1:0] fast_src,
    input wire logic [PIN_N-1:0] external_request_pin,
    input wire logic core_ack,
    output logic req_valid,
    output logic [7:0] req_vector
);
    function automatic logic vec_ok(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] pin_mode;
    logic [PIN_N-1:0] pin_filt;
    logic [15:0] grp_en [GRP_N];
    pic_slot_t slot [SLOTS];
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [PIN_N-1:0] pin_s1, pin_s2, pin_val, pin_prev, pin_lat;
    logic [FILT_LEN-1:0] pin_hist [PIN_N];
    logic [SLOW_N-1:0] slow_q, slow_lat;
    logic [FAST_N-1:0] fast_q, fast_lat;
    logic [SLOW_N-1:0] slow_pend, slow_clr;
    logic [FAST_N-1:0] fast_pend, fast_clr;
    logic [PIN_N-1:0] pin_req, pin_clr;
    logic [GRP_N-1:0] grp_req;
    logic [SLOTS-1:0] slot_req;
    logic next_valid;
    logic [7:0] next_vector;
    logic ack_hit, do_wr, wr_err;
    logic [31:0] wr_word, rd_word;
    logic rd_err;

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    assign do_wr = ce && !awready && !wready && !bvalid;
    assign wr_word = merge(32'h0000_0000, w_data, w_strb);

    function automatic logic [7:0] wdata_vec();
        return w_data[SLOT_VEC_LSB +: 8];
    endfunction

    always_comb begin
        wr_err = 1'b1;
        if (aw_addr == ADDR_PIN_MODE || aw_addr == ADDR_PIN_FILT ||
            aw_addr == ADDR_EDGE_STAT) begin
            wr_err = 1'b0;
        end
        for (int g = 0; g < GRP_N; g++) begin
            if (aw_addr == ADDR_GRP_EN0 + 8'(g) * ADDR_STEP) begin
                wr_err = 1'b0;
            end
        end
        for (int k = 0; k < SLOTS; k++) begin
            if (aw_addr == ADDR_SLOT0 + 8'(k) * ADDR_STEP) begin
                wr_err = !(k < SLOW_SLOTS
                    ? vec_ok(wdata_vec(), SLOW_VEC_MIN, SLOW_VEC_MAX)
                    : vec_ok(wdata_vec(), FAST_VEC_MIN, FAST_VEC_MAX));
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_wr) begin
                bvalid <= 1'b1;
                bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_mode <= PIN_MODE_RST;
            pin_filt <= '0;
            for (int g = 0; g < GRP_N; g++) begin
                grp_en[g] <= '0;
            end
            for (int k = 0; k < SLOTS; k++) begin
                slot[k] <= SLOT_RST;
            end
        end else if (do_wr && !wr_err) begin
            if (aw_addr == ADDR_PIN_MODE) begin
                pin_mode <= merge(pin_mode, w_data, w_strb);
            end
            if (aw_addr == ADDR_PIN_FILT) begin
                pin_filt <= 16'(merge({16'h0000, pin_filt}, w_data,
                                      w_strb));
            end
            for (int g = 0; g < GRP_N; g++) begin
                if (aw_addr == ADDR_GRP_EN0 + 8'(g) * ADDR_STEP) begin
                    grp_en[g] <= 16'(merge({16'h0000, grp_en[g]}, w_data,
                                           w_strb));
                end
            end
            for (int k = 0; k < SLOTS; k++) begin
                if (aw_addr == ADDR_SLOT0 + 8'(k) * ADDR_STEP) begin
                    slot[k] <= '{en: w_data[SLOT_EN_BIT],
                                 vec: w_data[SLOT_VEC_LSB +: 8],
                                 sel: w_data[SLOT_SEL_LSB +: 5]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        case (araddr)
            ADDR_PIN_MODE: rd_word = pin_mode;
            ADDR_PIN_FILT: rd_word = {16'h0000, pin_filt};
            ADDR_EDGE_STAT: rd_word = {16'h0000, slow_lat & GRP_SLOW_E0};
            ADDR_PIN_PEND: rd_word = {16'h0000, pin_req};
            ADDR_REQ: begin
                rd_word[REQ_VALID_BIT] = req_valid;
                rd_word[7:0] = req_vector;
            end
            default: rd_err = 1'b1;
        endcase
        for (int g = 0; g < GRP_N; g++) begin
            if (araddr == ADDR_GRP_EN0 + 8'(g) * ADDR_STEP) begin
                rd_word = {16'h0000, grp_en[g]};
                rd_err = 1'b0;
            end
        end
        for (int k = 0; k < SLOTS; k++) begin
            if (araddr == ADDR_SLOT0 + 8'(k) * ADDR_STEP) begin
                rd_word = 32'h0000_0000;
                rd_word[SLOT_EN_BIT] = slot[k].en;
                rd_word[SLOT_VEC_LSB +: 8] = slot[k].vec;
                rd_word[SLOT_SEL_LSB +: 5] = slot[k].sel;
                rd_err = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_err ? 32'h0000_0000 : rd_word;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser, filter, detection
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_val <= '1;
            pin_prev <= '1;
            for (int i = 0; i < PIN_N; i++) begin
                pin_hist[i] <= '1;
            end
        end else if (ce) begin
            pin_s1 <= external_request_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_val;
            for (int i = 0; i < PIN_N; i++) begin
                pin_hist[i] <= {pin_hist[i][FILT_LEN-2:0], pin_s2[i]};
                if (!pin_filt[i]) begin
                    pin_val[i] <= pin_s2[i];
                end else if (&pin_hist[i] || ~|pin_hist[i]) begin
                    pin_val[i] <= pin_hist[i][0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_lat <= '0;
        end else if (ce) begin
            for (int i = 0; i < PIN_N; i++) begin
                case (pic_pin_mode_t'(pin_mode[2*i +: 2]))
                    PM_FALL: pin_lat[i] <= (!pin_val[i] && pin_prev[i]) ||
                                           (pin_lat[i] && !pin_clr[i]);
                    PM_RISE: pin_lat[i] <= (pin_val[i] && !pin_prev[i]) ||
                                           (pin_lat[i] && !pin_clr[i]);
                    PM_BOTH: pin_lat[i] <= (pin_val[i] != pin_prev[i]) ||
                                           (pin_lat[i] && !pin_clr[i]);
                    default: pin_lat[i] <= 1'b0;
                endcase
            end
        end
    end

    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            pin_req[i] = (pic_pin_mode_t'(pin_mode[2*i +: 2]) == PM_LOW)
                       ? !pin_val[i] : pin_lat[i];
        end
    end

    // ------------------------------------------------------------
    // peripheral sources and groups
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_q <= '0;
            fast_q <= '0;
            slow_lat <= '0;
            fast_lat <= '0;
        end else if (ce) begin
            slow_q <= slow_src;
            fast_q <= fast_src;
            slow_lat <= SLOW_EDGE_SRC & ((slow_src & ~slow_q) |
                                         (slow_lat & ~slow_clr));
            fast_lat <= FAST_EDGE_SRC & ((fast_src & ~fast_q) |
                                         (fast_lat & ~fast_clr));
        end
    end

    assign slow_pend = slow_lat | (slow_src & ~SLOW_EDGE_SRC);
    assign fast_pend = fast_lat | (fast_src & ~FAST_EDGE_SRC);

    assign grp_req[0] = |(slow_pend & GRP_SLOW_E0 & grp_en[0]);
    assign grp_req[1] = |(slow_pend & GRP_SLOW_L0 & grp_en[1]);
    assign grp_req[2] = |(slow_pend & GRP_SLOW_L1 & grp_en[2]);
    assign grp_req[3] = |(slow_pend & GRP_SLOW_L2 & grp_en[3]);
    assign grp_req[4] = |(fast_pend & GRP_FAST_L0 & grp_en[4][7:0]);
    assign grp_req[5] = |(fast_pend & GRP_FAST_L1 & grp_en[5][7:0]);

    // ------------------------------------------------------------
    // slots, arbitration, acknowledge
    // ------------------------------------------------------------
    assign ack_hit = ce && core_ack && req_valid;

    always_comb begin
        slow_clr = '0;
        fast_clr = '0;
        pin_clr = '0;
        slot_req = '0;
        next_valid = 1'b0;
        next_vector = 8'h00;
        for (int k = SLOTS - 1; k >= 0; k--) begin
            if (k < SLOW_SLOTS) begin
                slot_req[k] = slot[k].en && slot[k].sel < 5'(SLOW_N) &&
                              slow_pend[slot[k].sel[3:0]];
            end else begin
                slot_req[k] = slot[k].en && slot[k].sel < 5'(FAST_N) &&
                              fast_pend[slot[k].sel[2:0]];
            end
            if (slot_req[k]) begin
                next_valid = 1'b1;
                next_vector = slot[k].vec;
            end
            if (ack_hit && slot[k].en && slot[k].vec == req_vector) begin
                if (k < SLOW_SLOTS) begin
                    slow_clr[slot[k].sel[3:0]] = 1'b1;
                end else begin
                    fast_clr[slot[k].sel[2:0]] = 1'b1;
                end
            end
        end
        if (do_wr && aw_addr == ADDR_EDGE_STAT) begin
            slow_clr = slow_clr | wr_word[SLOW_N-1:0];
        end
        for (int g = GRP_N - 1; g >= 0; g--) begin
            if (grp_req[g]) begin
                next_valid = 1'b1;
                next_vector = GRP_VEC_BASE + 8'(g);
            end
        end
        for (int i = PIN_N - 1; i >= 0; i--) begin
            if (pin_req[i]) begin
                next_valid = 1'b1;
                next_vector = PIN_VEC_BASE + 8'(i);
            end
            pin_clr[i] = ack_hit && req_vector == PIN_VEC_BASE + 8'(i);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_valid <= 1'b0;
            req_vector <= 8'h00;
        end else if (ce) begin
            req_valid <= next_valid && !ack_hit;
            req_vector <= next_vector;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_latch;
        ce && slow_src[0] && !slow_q[0] |=> slow_lat[0];
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("edge source not latched");

    property p_edge_grp;
        ce && slow_src[0] && !slow_q[0] && grp_en[0][0] |=> grp_req[0];
    endproperty
    a_edge_grp: assert property (p_edge_grp)
        else $error("edge group missed member");

    property p_slow_lvl;
        !(|(slow_src & GRP_SLOW_L0)) |-> !grp_req[1];
    endproperty
    a_slow_lvl: assert property (p_slow_lvl)
        else $error("level group held without source");

    property p_fast_lvl;
        !(|(fast_src & GRP_FAST_L0)) |-> !grp_req[4];
    endproperty
    a_fast_lvl: assert property (p_fast_lvl)
        else $error("fast group held without source");

    property p_grp_to_req;
        ce && grp_req[2] && !ack_hit |=> req_valid;
    endproperty
    a_grp_to_req: assert property (p_grp_to_req)
        else $error("group request not presented");

    property p_slow_range;
        slot[0].en |-> vec_ok(slot[0].vec, SLOW_VEC_MIN, SLOW_VEC_MAX);
    endproperty
    a_slow_range: assert property (p_slow_range)
        else $error("slow slot vector out of range");

    property p_fast_range;
        slot[4].en |-> vec_ok(slot[4].vec, FAST_VEC_MIN, FAST_VEC_MAX);
    endproperty
    a_fast_range: assert property (p_fast_range)
        else $error("fast slot vector out of range");

    property p_pin_low;
        pin_mode[1:0] == PM_LOW && !pin_val[0] |-> pin_req[0];
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("low level pin not requesting");

    property p_filter;
        ce && pin_filt[3] && !(&pin_hist[3] || ~|pin_hist[3])
            |=> $stable(pin_val[3]);
    endproperty
    a_filter: assert property (p_filter)
        else $error("filtered pin moved on a glitch");

    property p_ack_drop;
        ack_hit |=> !req_valid;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request held after acknowledge");

    c_pin_ack: cover property (ack_hit && req_vector == PIN_VEC_BASE);
    c_slot_req: cover property (slot_req[0] ##1 req_valid);
    c_grp_req: cover property (grp_req[0] ##1 req_valid);
endmodule

// ### include/pic_pkg.sv
/*
 * constants, field layouts and types of the peripheral and pin
 * interrupt unit; assumes a 32-bit AXI4-Lite register bus
 */
package pic_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PIN_N = 16;
    localparam int SLOW_N = 16;
    localparam int FAST_N = 8;
    localparam int SLOW_SLOTS = 4;
    localparam int SLOTS = 6;
    localparam int GRP_N = 6;
    localparam int FILT_LEN = 3;
    // ------------------------------------------------------------
    // vector numbers
    // ------------------------------------------------------------
    localparam logic [7:0] SLOW_VEC_MIN = 8'h80;
    localparam logic [7:0] SLOW_VEC_MAX = 8'hcf;
    localparam logic [7:0] FAST_VEC_MIN = 8'hd0;
    localparam logic [7:0] FAST_VEC_MAX = 8'hff;
    localparam logic [7:0] PIN_VEC_BASE = 8'h40;
    localparam logic [7:0] GRP_VEC_BASE = 8'h6a;
    // ------------------------------------------------------------
    // fixed detection type and group membership
    // ------------------------------------------------------------
    localparam logic [15:0] SLOW_EDGE_SRC = 16'h00ff;
    localparam logic [7:0] FAST_EDGE_SRC = 8'h0f;
    localparam logic [15:0] GRP_SLOW_E0 = 16'h00ff;
    localparam logic [15:0] GRP_SLOW_L0 = 16'h0f00;
    localparam logic [15:0] GRP_SLOW_L1 = 16'h3000;
    localparam logic [15:0] GRP_SLOW_L2 = 16'hc000;
    localparam logic [7:0] GRP_FAST_L0 = 8'h30;
    localparam logic [7:0] GRP_FAST_L1 = 8'hc0;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_MODE = 8'h00;
    localparam logic [7:0] ADDR_PIN_FILT = 8'h04;
    localparam logic [7:0] ADDR_GRP_EN0 = 8'h08;
    localparam logic [7:0] ADDR_EDGE_STAT = 8'h20;
    localparam logic [7:0] ADDR_PIN_PEND = 8'h24;
    localparam logic [7:0] ADDR_REQ = 8'h28;
    localparam logic [7:0] ADDR_SLOT0 = 8'h40;
    localparam logic [7:0] ADDR_STEP = 8'h04;
    localparam int SLOT_SEL_LSB = 0;
    localparam int SLOT_VEC_LSB = 8;
    localparam int SLOT_EN_BIT = 31;
    localparam int REQ_VALID_BIT = 31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] PIN_MODE_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PM_LOW = 2'h0,
        PM_FALL = 2'h1,
        PM_RISE = 2'h2,
        PM_BOTH = 2'h3
    } pic_pin_mode_t;

    typedef struct packed {
        logic en;
        logic [7:0] vec;
        logic [4:0] sel;
    } pic_slot_t;

    localparam pic_slot_t SLOT_RST = '0;
endpackage

// ### verification/pic_core_model.sv
/* core model: takes a presented vector after ack_dly cycles
   assumes req_valid and req_vector are registered on aclk */
`timescale 1ns/100ps
module pic_core_model
    import pic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ack_en,
    input wire logic [1:0] ack_dly,
    input wire logic req_valid,
    input wire logic [7:0] req_vector,
    output logic core_ack,
    output logic [7:0] taken_vec
);
    logic [1:0] cnt;
    // one-cycle take pulse, prompt or slow
    always_ff @(posedge aclk) begin
        if (!aresetn || !ack_en || !req_valid || core_ack) begin
            cnt <= 2'h0;
            core_ack <= 1'b0;
        end else if (cnt == ack_dly) begin
            core_ack <= 1'b1;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taken_vec <= 8'h0;
        end else if (core_ack && req_valid) begin
            taken_vec <= req_vector;
        end
    end
endmodule

// ### verification/tb_pic_unit.sv
/* bench for pic_unit: axi4-lite master, source and pin stimulus
   assumes pic_core_model on the vector side */
`timescale 1ns/100ps
module tb_pic_unit
    import pic_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, ack_en = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, req_vector, taken_vec;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, ack_dly = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, req_valid, core_ack;
    logic [SLOW_N-1:0] slow_src = 16'h0;
    logic [FAST_N-1:0] fast_src = 8'h0;
    logic [PIN_N-1:0] pin = 16'hffff;
    int error_cnt = 0, checks_done = 0;
    always #12.5 aclk = ~aclk;
    pic_unit i_pic_unit (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .slow_src(slow_src), .fast_src(fast_src),
        .external_request_pin(pin), .core_ack(core_ack),
        .req_valid(req_valid), .req_vector(req_vector)
    );
    pic_core_model i_pic_core_model (
        .aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
        .ack_dly(ack_dly), .req_valid(req_valid),
        .req_vector(req_vector), .core_ack(core_ack),
        .taken_vec(taken_vec)
    );
    // ------------------------------------------------------------
    // bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic finish_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic ka, kw, da, dw;
        int n;
        da = 1'b0;
        dw = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(da && dw) && n++ < 50) begin
            @(negedge aclk);
            ka = awvalid && awready;
            kw = wvalid && wready;
            @(posedge aclk);
            if (ka) awvalid <= 1'b0;
            if (kw) wvalid <= 1'b0;
            da = da | ka;
            dw = dw | kw;
        end
        do @(negedge aclk); while (!bvalid && n++ < 50);
        chk(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready && n++ < 50);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid && n++ < 50);
        chk({rresp, rdata}, {er, ed});
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // request expected or absent, vector ignored when absent
    task automatic expq(input logic e, input logic [7:0] v);
        int n;
        n = 0;
        if (!e) repeat (12) @(negedge aclk);
        else do @(negedge aclk); while (!req_valid && n++ < 12);
        chk({req_valid, req_vector & {8{e}}}, {e, v & {8{e}}});
    endtask
    task automatic t_reset;
        chk({awready, wready, arready, bvalid, rvalid, req_valid}, 6'h38);
        rchk(ADDR_PIN_MODE, PIN_MODE_RST, RESP_OKAY);
        rchk(8'h30, 32'h0, RESP_SLVERR);
        wr(ADDR_PIN_PEND, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_pin_level;
        for (int i = 0; i < PIN_N; i++) begin
            @(posedge aclk);
            pin[i] <= 1'b0;
            expq(1'b1, PIN_VEC_BASE + 8'(i));
            @(posedge aclk);
            pin[i] <= 1'b1;
            expq(1'b0, 8'h0);
        end
    endtask
    task automatic t_pin_edge;
        wr(ADDR_PIN_MODE, 32'h0000_00e4, RESP_OKAY);
        rchk(ADDR_PIN_MODE, 32'h0000_00e4, RESP_OKAY);
        for (int i = 1; i < 4; i++) begin
            @(posedge aclk);
            pin[i] <= 1'b0;
            expq(i != 2, PIN_VEC_BASE + 8'(i));
            @(posedge aclk);
            pin[i] <= 1'b1;
            repeat (8) @(posedge aclk);
            expq(1'b1, PIN_VEC_BASE + 8'(i));
            @(posedge aclk);
            ack_dly <= 2'(i);
            ack_en <= 1'b1;
            expq(1'b0, 8'h0);
            chk(taken_vec, PIN_VEC_BASE + 8'(i));
            @(posedge aclk);
            ack_en <= 1'b0;
        end
        wr(ADDR_PIN_MODE, 32'h0, RESP_OKAY);
    endtask
    task automatic t_filter;
        wr(ADDR_PIN_FILT, 32'h0000_0040, RESP_OKAY);
        for (int i = 6; i < 8; i++) begin
            @(posedge aclk);
            pin[i] <= 1'b0;
            repeat (2) @(posedge aclk);
            pin[i] <= 1'b1;
            expq(i == 7, PIN_VEC_BASE + 8'(i));
        end
        repeat (8) @(posedge aclk);
        pin[6] <= 1'b0;
        expq(1'b1, PIN_VEC_BASE + 8'h6);
        @(posedge aclk);
        pin[6] <= 1'b1;
        expq(1'b0, 8'h0);
    endtask
    task automatic t_group;
        logic [4:0] src [5] = '{5'h8, 5'hc, 5'he, 5'h14, 5'h16};
        wr(ADDR_GRP_EN0, 32'h0000_0001, RESP_OKAY);
        for (int k = 1; k >= 0; k--) begin
            @(posedge aclk);
            slow_src <= 16'(1 << k);
            @(posedge aclk);
            slow_src <= 16'h0;
            repeat (8) @(posedge aclk);
            expq(k == 0, GRP_VEC_BASE);
        end
        rchk(ADDR_EDGE_STAT, 32'h0000_0003, RESP_OKAY);
        wr(ADDR_EDGE_STAT, 32'h0000_0003, RESP_OKAY);
        expq(1'b0, 8'h0);
        wr(ADDR_GRP_EN0, 32'h0, RESP_OKAY);
        for (int g = 1; g < GRP_N; g++) begin
            wr(ADDR_GRP_EN0 + 8'(4 * g), 32'h0000_ffff, RESP_OKAY);
            @(posedge aclk);
            {fast_src, slow_src} <= 24'h1 << src[g-1];
            expq(1'b1, GRP_VEC_BASE + 8'(g));
            @(posedge aclk);
            {fast_src, slow_src} <= 24'h0;
            expq(1'b0, 8'h0);
            wr(ADDR_GRP_EN0 + 8'(4 * g), 32'h0, RESP_OKAY);
        end
    endtask
    task automatic t_slot;
        logic [31:0] d [4] = '{32'h8000_7f0a, 32'h8000_cf0a,
            32'h8000_cf05, 32'h8000_d005};
        for (int k = 0; k < 4; k++)
            wr(k < 2 ? ADDR_SLOT0 : 8'h50, d[k],
                k[0] ? RESP_OKAY : RESP_SLVERR);
        rchk(ADDR_SLOT0, 32'h8000_cf0a, RESP_OKAY);
        @(posedge aclk);
        slow_src <= 16'h0400;
        expq(1'b1, SLOW_VEC_MAX);
        rchk(ADDR_REQ, 32'h8000_00cf, RESP_OKAY);
        @(posedge aclk);
        ce <= 1'b0;
        slow_src <= 16'h0;
        repeat (4) @(negedge aclk);
        chk({req_valid, req_vector}, 9'h1cf);
        @(posedge aclk);
        ce <= 1'b1;
        fast_src <= 8'h20;
        @(posedge aclk);
        expq(1'b1, FAST_VEC_MIN);
        @(posedge aclk);
        fast_src <= 8'h0;
        expq(1'b0, 8'h0);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset();
        t_pin_level();
        t_pin_edge();
        t_filter();
        t_group();
        t_slot();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        finish_test();
    end
endmodule
